// ===== pmu_ctrl_pkg.sv
// Shared constants and types for the regulator enable and mode control
package pmu_ctrl_pkg;

  // ----------------------------------------
  // Clock
  // ----------------------------------------
  localparam int CLK_MHZ = 50;

  // ----------------------------------------
  // Resource map
  // ----------------------------------------
  localparam int NUM_LDO = 10;
  localparam int NUM_CONV = 4;
  localparam int NUM_RES = 20;
  localparam int RES_CONV0 = 10;
  localparam int RES_CLK32 = 14;
  localparam int RES_GPIO0 = 15;
  localparam int NUM_SLOTS = 15;
  localparam int SLOT_W = 4;
  localparam int VSEL_W = 6;
  localparam int VSEL_TOP_BIT = 5;
  localparam int LOW_NOISE_A = 3;
  localparam int LOW_NOISE_B = 4;
  localparam int OK_FIRST_W = 8;
  localparam int OK_SECOND_W = 2;

  // ----------------------------------------
  // Request sources
  // ----------------------------------------
  localparam int NUM_REQ = 7;
  localparam int NUM_EN_PIN = 4;
  localparam int REQ_CLK1 = 4;
  localparam int REQ_CLK2 = 5;
  localparam int REQ_PWR = 6;
  localparam int SYNC_W = 25;

  // ----------------------------------------
  // Control fields
  // ----------------------------------------
  localparam int THERM_WARN_EN_BIT = 0;
  localparam int THERM_LVL_LSB = 1;
  localparam int THERM_LVL_W = 2;
  localparam int CONV4_RAMP_BIT = 0;
  localparam int CONV4_IDX = 3;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int SLOT_T0_US = 30;
  localparam int SLOT_T1_US = 200;
  localparam int SLOT_T2_US = 500;
  localparam int SLOT_T3_US = 2000;
  localparam int SLOT_CYC0 = SLOT_T0_US * CLK_MHZ;
  localparam int TMR_W = 17;
  localparam int T_START_US = 40;
  localparam int T_RAMP_US = 60;
  localparam int T_START_FAST_US = 20;
  localparam int T_RAMP_FAST_US = 30;
  localparam int START_CYC = T_START_US * CLK_MHZ;
  localparam int RAMP_CYC = T_RAMP_US * CLK_MHZ;
  localparam int START_FAST_CYC = T_START_FAST_US * CLK_MHZ;
  localparam int RAMP_FAST_CYC = T_RAMP_FAST_US * CLK_MHZ;
  localparam int CV_CNT_W = 12;

  // ----------------------------------------
  // States
  // ----------------------------------------
  typedef enum logic [1:0] {
    SEQ_OFF = 2'h0,
    SEQ_UP = 2'h1,
    SEQ_ACTIVE = 2'h3,
    SEQ_DOWN = 2'h2
  } seq_state_t;

  typedef enum logic [1:0] {
    CV_IDLE = 2'h0,
    CV_DELAY = 2'h1,
    CV_RAMP = 2'h3,
    CV_ON = 2'h2
  } conv_state_t;

endpackage

// ===== conv_ctrl_if.sv
// Control and status bundle between the core and one converter unit
`timescale 1ns/1ns
interface conv_ctrl_if;
  logic enable;
  logic mode;
  logic eco;
  logic dis;
  logic fast;
  logic pg_low;
  logic [pmu_ctrl_pkg::VSEL_W-1:0] vsel;
  logic pwm_force;
  logic eco_on;
  logic discharge;
  logic ramping;
  logic pg_ok;
  logic [pmu_ctrl_pkg::VSEL_W-1:0] vout;

  modport core (
    output enable, mode, eco, dis, fast, pg_low, vsel,
    input pwm_force, eco_on, discharge, ramping, pg_ok, vout
  );
  modport unit (
    input enable, mode, eco, dis, fast, pg_low, vsel,
    output pwm_force, eco_on, discharge, ramping, pg_ok, vout
  );
endinterface

// ===== sync2.sv
// Two-stage synchroniser for asynchronous level inputs
`timescale 1ns/1ns
module sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // Only the second stage is ever looked at
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule

// ===== conv_unit.sv
// One step-down converter: start delay, soft start, mode and output supervision
`timescale 1ns/1ns
module conv_unit (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Core side
  conv_ctrl_if.unit bus
);

  pmu_ctrl_pkg::conv_state_t state_ff, nxt_state;
  logic [pmu_ctrl_pkg::CV_CNT_W-1:0] cnt_ff, nxt_cnt;
  logic [pmu_ctrl_pkg::VSEL_W-1:0] vout_ff, nxt_vout;
  logic pwm_ff, nxt_pwm;
  logic eco_ff, nxt_eco;
  logic dis_ff, nxt_dis;
  logic ramp_ff, nxt_ramp;
  logic ok_ff, nxt_ok;
  logic [pmu_ctrl_pkg::CV_CNT_W-1:0] start_cnt;
  logic [pmu_ctrl_pkg::CV_CNT_W-1:0] ramp_cnt;

  always_comb begin
    start_cnt = bus.fast ? pmu_ctrl_pkg::CV_CNT_W'(pmu_ctrl_pkg::START_FAST_CYC - 1)
                         : pmu_ctrl_pkg::CV_CNT_W'(pmu_ctrl_pkg::START_CYC - 1);
    ramp_cnt = bus.fast ? pmu_ctrl_pkg::CV_CNT_W'(pmu_ctrl_pkg::RAMP_FAST_CYC - 1)
                        : pmu_ctrl_pkg::CV_CNT_W'(pmu_ctrl_pkg::RAMP_CYC - 1);
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_vout = vout_ff;
    case (state_ff)
      pmu_ctrl_pkg::CV_IDLE: begin
        nxt_vout = bus.vsel;
        if (bus.enable) begin
          nxt_state = pmu_ctrl_pkg::CV_DELAY;
          nxt_cnt = start_cnt;
        end
      end
      pmu_ctrl_pkg::CV_DELAY: begin
        nxt_vout = bus.vsel;
        if (!bus.enable) begin
          nxt_state = pmu_ctrl_pkg::CV_IDLE;
        end else if (cnt_ff == '0) begin
          nxt_state = pmu_ctrl_pkg::CV_RAMP;
          nxt_cnt = ramp_cnt;
        end else begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      end
      pmu_ctrl_pkg::CV_RAMP: begin
        nxt_vout = bus.vsel;
        if (!bus.enable) begin
          nxt_state = pmu_ctrl_pkg::CV_IDLE;
        end else if (cnt_ff == '0) begin
          nxt_state = pmu_ctrl_pkg::CV_ON;
        end else begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      end
      pmu_ctrl_pkg::CV_ON: begin
        if (!bus.enable) begin
          nxt_state = pmu_ctrl_pkg::CV_IDLE;
        end else if (vout_ff < bus.vsel) begin
          nxt_vout = vout_ff + 1'b1;
        end else if (vout_ff > bus.vsel) begin
          nxt_vout = vout_ff - 1'b1;
        end
      end
      default: begin
        nxt_state = pmu_ctrl_pkg::CV_IDLE;
      end
    endcase
    nxt_pwm = bus.mode;
    nxt_eco = bus.eco & ~bus.mode;
    nxt_dis = bus.dis & ~bus.enable;
    nxt_ramp = (nxt_state == pmu_ctrl_pkg::CV_RAMP);
    // Blanked while off, starting or stepping between set points
    nxt_ok = (state_ff == pmu_ctrl_pkg::CV_ON) && bus.enable
             && (vout_ff == bus.vsel) && !bus.pg_low;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= pmu_ctrl_pkg::CV_IDLE;
      cnt_ff <= '0;
      vout_ff <= '0;
      pwm_ff <= 1'b0;
      eco_ff <= 1'b0;
      dis_ff <= 1'b0;
      ramp_ff <= 1'b0;
      ok_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      vout_ff <= nxt_vout;
      pwm_ff <= nxt_pwm;
      eco_ff <= nxt_eco;
      dis_ff <= nxt_dis;
      ramp_ff <= nxt_ramp;
      ok_ff <= nxt_ok;
    end
  end

  assign bus.pwm_force = pwm_ff;
  assign bus.eco_on = eco_ff;
  assign bus.discharge = dis_ff;
  assign bus.ramping = ramp_ff;
  assign bus.pg_ok = ok_ff;
  assign bus.vout = vout_ff;

endmodule

// ===== pmu_power_control.sv
// Regulator enable sequencing, pin mapping, mode and supervision control
`timescale 1ns/1ns
module pmu_power_control #(
  parameter int SLOT_CYC1 = pmu_ctrl_pkg::SLOT_T1_US * pmu_ctrl_pkg::CLK_MHZ,
  parameter int SLOT_CYC2 = pmu_ctrl_pkg::SLOT_T2_US * pmu_ctrl_pkg::CLK_MHZ,
  parameter int SLOT_CYC3 = pmu_ctrl_pkg::SLOT_T3_US * pmu_ctrl_pkg::CLK_MHZ
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Request pins
  input wire logic [pmu_ctrl_pkg::NUM_EN_PIN-1:0] en_pin,
  input wire logic clock_request_one,
  input wire logic clock_request_two,
  input wire logic power_request,
  // Power-on and power-off conditions
  input wire logic power_on_cond,
  input wire logic power_off_cond,
  // Analog comparators
  input wire logic temp_warn_cmp,
  input wire logic temp_shutdown_cmp,
  input wire logic [pmu_ctrl_pkg::NUM_LDO-1:0] ldo_pg_cmp,
  input wire logic [pmu_ctrl_pkg::NUM_CONV-1:0] conv_pg_low,
  // Sequencing and mapping control
  input wire logic [pmu_ctrl_pkg::NUM_RES-1:0] res_reg_enable,
  input wire logic [pmu_ctrl_pkg::NUM_RES-1:0][pmu_ctrl_pkg::SLOT_W-1:0] res_slot,
  input wire logic [pmu_ctrl_pkg::NUM_REQ-1:0][pmu_ctrl_pkg::NUM_RES-1:0] req_map,
  input wire logic [1:0] slot_spacing_field,
  // Thermal control
  input wire logic [7:0] thermal_config_register,
  input wire logic thermal_flag_clear,
  // Linear regulator control
  input wire logic [pmu_ctrl_pkg::NUM_LDO-1:0][pmu_ctrl_pkg::VSEL_W-1:0] ldo_vsel,
  input wire logic [pmu_ctrl_pkg::NUM_LDO-1:0] ldo_eco,
  input wire logic [pmu_ctrl_pkg::NUM_LDO-1:0] ldo_discharge,
  // Converter control
  input wire logic [pmu_ctrl_pkg::NUM_CONV-1:0] converter_forced_fixed_freq,
  input wire logic [pmu_ctrl_pkg::NUM_CONV-1:0] conv_eco,
  input wire logic [pmu_ctrl_pkg::NUM_CONV-1:0] conv_discharge,
  input wire logic [pmu_ctrl_pkg::NUM_CONV-1:0][pmu_ctrl_pkg::VSEL_W-1:0] conv_vsel,
  input wire logic [7:0] fourth_converter_control,
  input wire logic [pmu_ctrl_pkg::NUM_CONV-1:0] conv_fault_mask,
  // Resource enables
  output logic [pmu_ctrl_pkg::NUM_RES-1:0] res_on,
  output logic device_on,
  // Linear regulator outputs
  output logic [pmu_ctrl_pkg::NUM_LDO-1:0][pmu_ctrl_pkg::VSEL_W-1:0] ldo_vout_code,
  output logic [pmu_ctrl_pkg::NUM_LDO-1:0] ldo_eco_on,
  output logic [pmu_ctrl_pkg::NUM_LDO-1:0] ldo_discharge_on,
  output logic [pmu_ctrl_pkg::OK_FIRST_W-1:0] output_ok_flags,
  output logic [pmu_ctrl_pkg::OK_SECOND_W-1:0] output_ok_flags_second,
  // Converter outputs
  output logic [pmu_ctrl_pkg::NUM_CONV-1:0] conv_pwm_force,
  output logic [pmu_ctrl_pkg::NUM_CONV-1:0] conv_eco_on,
  output logic [pmu_ctrl_pkg::NUM_CONV-1:0] conv_discharge_on,
  output logic [pmu_ctrl_pkg::NUM_CONV-1:0][pmu_ctrl_pkg::VSEL_W-1:0] conv_vout_code,
  output logic [pmu_ctrl_pkg::NUM_CONV-1:0] conv_soft_start,
  output logic [pmu_ctrl_pkg::NUM_CONV-1:0] conv_output_ok,
  output logic [pmu_ctrl_pkg::NUM_CONV-1:0] conv_fault_event,
  // Thermal outputs
  output logic temp_warning,
  output logic [pmu_ctrl_pkg::THERM_LVL_W-1:0] temp_warn_level,
  output logic thermal_shutdown_flag
);

  // ----------------------------------------
  // Input synchronisation
  // ----------------------------------------
  logic [pmu_ctrl_pkg::SYNC_W-1:0] raw_in;
  logic [pmu_ctrl_pkg::SYNC_W-1:0] syn_in;
  logic [pmu_ctrl_pkg::NUM_REQ-1:0] req_s;
  logic on_cond_s;
  logic off_cond_s;
  logic warn_s;
  logic shut_s;
  logic [pmu_ctrl_pkg::NUM_LDO-1:0] ldo_pg_s;
  logic [pmu_ctrl_pkg::NUM_CONV-1:0] conv_low_s;
  assign raw_in = {conv_pg_low, ldo_pg_cmp, temp_shutdown_cmp, temp_warn_cmp,
                   power_off_cond, power_on_cond, power_request,
                   clock_request_two, clock_request_one, en_pin};
  sync2 #(.W(pmu_ctrl_pkg::SYNC_W)) u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .async_in(raw_in),
    .sync_out(syn_in)
  );
  assign req_s = syn_in[6:0];
  assign on_cond_s = syn_in[7];
  assign off_cond_s = syn_in[8];
  assign warn_s = syn_in[9];
  assign shut_s = syn_in[10];
  assign ldo_pg_s = syn_in[20:11];
  assign conv_low_s = syn_in[24:21];

  // ----------------------------------------
  // Slot sequencer
  // ----------------------------------------
  pmu_ctrl_pkg::seq_state_t seq_ff, nxt_seq;
  logic [pmu_ctrl_pkg::SLOT_W-1:0] slot_ff, nxt_slot;
  logic [pmu_ctrl_pkg::TMR_W-1:0] tmr_ff, nxt_tmr;
  logic [pmu_ctrl_pkg::TMR_W-1:0] slot_last;
  logic slot_done;
  always_comb begin
    case (slot_spacing_field)
      2'h0: slot_last = pmu_ctrl_pkg::TMR_W'(pmu_ctrl_pkg::SLOT_CYC0 - 1);
      2'h1: slot_last = pmu_ctrl_pkg::TMR_W'(SLOT_CYC1 - 1);
      2'h2: slot_last = pmu_ctrl_pkg::TMR_W'(SLOT_CYC2 - 1);
      default: slot_last = pmu_ctrl_pkg::TMR_W'(SLOT_CYC3 - 1);
    endcase
    slot_done = (tmr_ff >= slot_last);
    nxt_seq = seq_ff;
    nxt_slot = slot_ff;
    nxt_tmr = '0;
    case (seq_ff)
      pmu_ctrl_pkg::SEQ_OFF: begin
        nxt_slot = '0;
        if (on_cond_s && !shut_s) begin
          nxt_seq = pmu_ctrl_pkg::SEQ_UP;
        end
      end
      pmu_ctrl_pkg::SEQ_UP: begin
        if (off_cond_s) begin
          nxt_seq = pmu_ctrl_pkg::SEQ_DOWN;
        end else if (slot_done) begin
          if (slot_ff == pmu_ctrl_pkg::SLOT_W'(pmu_ctrl_pkg::NUM_SLOTS)) begin
            nxt_seq = pmu_ctrl_pkg::SEQ_ACTIVE;
          end else begin
            nxt_slot = slot_ff + 1'b1;
          end
        end else begin
          nxt_tmr = tmr_ff + 1'b1;
        end
      end
      pmu_ctrl_pkg::SEQ_ACTIVE: begin
        if (off_cond_s) begin
          nxt_seq = pmu_ctrl_pkg::SEQ_DOWN;
        end
      end
      pmu_ctrl_pkg::SEQ_DOWN: begin
        // Slots are released in reverse order
        if (slot_done) begin
          if (slot_ff == '0) begin
            nxt_seq = pmu_ctrl_pkg::SEQ_OFF;
          end else begin
            nxt_slot = slot_ff - 1'b1;
          end
        end else begin
          nxt_tmr = tmr_ff + 1'b1;
        end
      end
      default: begin
        nxt_seq = pmu_ctrl_pkg::SEQ_OFF;
      end
    endcase
    // Shutdown skips the orderly power-down
    if (shut_s) begin
      nxt_seq = pmu_ctrl_pkg::SEQ_OFF;
      nxt_slot = '0;
      nxt_tmr = '0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      seq_ff <= pmu_ctrl_pkg::SEQ_OFF;
      slot_ff <= '0;
      tmr_ff <= '0;
    end else begin
      seq_ff <= nxt_seq;
      slot_ff <= nxt_slot;
      tmr_ff <= nxt_tmr;
    end
  end

  // ----------------------------------------
  // Resource enables
  // ----------------------------------------
  logic [pmu_ctrl_pkg::NUM_RES-1:0] res_on_ff, nxt_res_on;
  logic [pmu_ctrl_pkg::NUM_RES-1:0] pin_on;
  logic [pmu_ctrl_pkg::NUM_RES-1:0] slot_on;
  always_comb begin
    pin_on = '0;
    for (int r = 0; r < pmu_ctrl_pkg::NUM_REQ; r++) begin
      if (req_s[r]) begin
        pin_on = pin_on | req_map[r];
      end
    end
    for (int i = 0; i < pmu_ctrl_pkg::NUM_RES; i++) begin
      slot_on[i] = (res_slot[i] != '0) && (res_slot[i] <= slot_ff);
    end
    if (seq_ff == pmu_ctrl_pkg::SEQ_OFF || shut_s) begin
      nxt_res_on = '0;
    end else begin
      nxt_res_on = slot_on | res_reg_enable | pin_on;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      res_on_ff <= '0;
    end else begin
      res_on_ff <= nxt_res_on;
    end
  end
  assign res_on = res_on_ff;
  assign device_on = (seq_ff != pmu_ctrl_pkg::SEQ_OFF);
  // ----------------------------------------
  // Linear regulators
  // ----------------------------------------
  logic [pmu_ctrl_pkg::NUM_LDO-1:0][pmu_ctrl_pkg::VSEL_W-1:0] lvout_ff, nxt_lvout;
  logic [pmu_ctrl_pkg::NUM_LDO-1:0] leco_ff, nxt_leco;
  logic [pmu_ctrl_pkg::NUM_LDO-1:0] ldis_ff, nxt_ldis;
  logic [pmu_ctrl_pkg::NUM_LDO-1:0] lok_ff, nxt_lok;
  logic [pmu_ctrl_pkg::VSEL_W-1:0] code;
  always_comb begin
    nxt_lvout = lvout_ff;
    code = '0;
    for (int i = 0; i < pmu_ctrl_pkg::NUM_LDO; i++) begin
      code = ldo_vsel[i];
      if (i == pmu_ctrl_pkg::LOW_NOISE_A || i == pmu_ctrl_pkg::LOW_NOISE_B) begin
        code[pmu_ctrl_pkg::VSEL_TOP_BIT] = 1'b1;
      end
      // A disabled regulator picks up the latest code when it turns on
      if (nxt_res_on[i]) begin
        nxt_lvout[i] = code;
      end
    end
    nxt_leco = ldo_eco;
    nxt_ldis = ldo_discharge & ~nxt_res_on[pmu_ctrl_pkg::NUM_LDO-1:0];
    nxt_lok = ldo_pg_s;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lvout_ff <= '0;
      leco_ff <= '0;
      ldis_ff <= '0;
      lok_ff <= '0;
    end else begin
      lvout_ff <= nxt_lvout;
      leco_ff <= nxt_leco;
      ldis_ff <= nxt_ldis;
      lok_ff <= nxt_lok;
    end
  end
  assign ldo_vout_code = lvout_ff;
  assign ldo_eco_on = leco_ff;
  assign ldo_discharge_on = ldis_ff;
  assign output_ok_flags = lok_ff[pmu_ctrl_pkg::OK_FIRST_W-1:0];
  assign output_ok_flags_second = lok_ff[pmu_ctrl_pkg::NUM_LDO-1:pmu_ctrl_pkg::OK_FIRST_W];
  // ----------------------------------------
  // Step-down converters
  // ----------------------------------------
  conv_ctrl_if cif[pmu_ctrl_pkg::NUM_CONV]();
  for (genvar c = 0; c < pmu_ctrl_pkg::NUM_CONV; c++) begin : g_conv
    assign cif[c].enable = res_on_ff[pmu_ctrl_pkg::RES_CONV0 + c];
    assign cif[c].mode = converter_forced_fixed_freq[c];
    assign cif[c].eco = conv_eco[c];
    // Next enable gates too, so discharge never overlaps the first on cycle
    assign cif[c].dis = conv_discharge[c] & ~nxt_res_on[pmu_ctrl_pkg::RES_CONV0 + c];
    assign cif[c].vsel = conv_vsel[c];
    assign cif[c].pg_low = conv_low_s[c];
    // Only the fourth converter has selectable timing
    assign cif[c].fast = (c == pmu_ctrl_pkg::CONV4_IDX) ?
                         fourth_converter_control[pmu_ctrl_pkg::CONV4_RAMP_BIT] : 1'b0;
    conv_unit u_conv (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .bus(cif[c])
    );
    assign conv_pwm_force[c] = cif[c].pwm_force;
    assign conv_eco_on[c] = cif[c].eco_on;
    assign conv_discharge_on[c] = cif[c].discharge;
    assign conv_vout_code[c] = cif[c].vout;
    assign conv_soft_start[c] = cif[c].ramping;
    assign conv_output_ok[c] = cif[c].pg_ok;
  end

  // ----------------------------------------
  // Converter fault events and thermal
  // ----------------------------------------
  logic [pmu_ctrl_pkg::NUM_CONV-1:0] fault_ff, nxt_fault;
  logic warn_ff, nxt_warn;
  logic shut_flag_ff, nxt_shut_flag;
  always_comb begin
    // Low output reported for unmasked enabled converters outside soft start, so also during start delay and set point steps
    nxt_fault = conv_low_s & ~conv_fault_mask
                & res_on_ff[pmu_ctrl_pkg::RES_CONV0 +: pmu_ctrl_pkg::NUM_CONV]
                & ~conv_soft_start;
    nxt_warn = warn_s & thermal_config_register[pmu_ctrl_pkg::THERM_WARN_EN_BIT];
    nxt_shut_flag = shut_flag_ff;
    if (thermal_flag_clear) begin
      nxt_shut_flag = 1'b0;
    end
    if (shut_s) begin
      nxt_shut_flag = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_ff <= '0;
      warn_ff <= 1'b0;
      shut_flag_ff <= 1'b0;
    end else begin
      fault_ff <= nxt_fault;
      warn_ff <= nxt_warn;
      shut_flag_ff <= nxt_shut_flag;
    end
  end
  assign conv_fault_event = fault_ff;
  assign temp_warning = warn_ff;
  assign temp_warn_level =
    thermal_config_register[pmu_ctrl_pkg::THERM_LVL_LSB +: pmu_ctrl_pkg::THERM_LVL_W];
  assign thermal_shutdown_flag = shut_flag_ff;

endmodule

// ===== pmu_power_control_props.sv
// Port checks for the power control block
`timescale 1ns/1ns
module pmu_power_control_props (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Watched ports
  input wire logic [19:0] res_on,
  input wire logic device_on,
  input wire logic [9:0][5:0] ldo_vsel,
  input wire logic [9:0][5:0] ldo_vout_code,
  input wire logic [9:0] ldo_eco,
  input wire logic [9:0] ldo_eco_on,
  input wire logic [9:0] ldo_discharge_on,
  input wire logic [9:0] ldo_discharge,
  input wire logic [3:0] converter_forced_fixed_freq,
  input wire logic [3:0] conv_eco,
  input wire logic [3:0] conv_discharge,
  input wire logic [3:0] conv_pwm_force,
  input wire logic [3:0] conv_eco_on,
  input wire logic [3:0] conv_discharge_on,
  input wire logic [3:0] conv_soft_start,
  input wire logic [3:0] conv_output_ok,
  input wire logic [7:0] fourth_converter_control
);
  // ----
  // Start delay counter of the fourth converter
  // ----
  logic [12:0] cnt_ff;
  logic [12:0] nxt_cnt;
  int st_exp;
  always_comb begin
    nxt_cnt = res_on[13] ? cnt_ff + 13'h1 : 13'h0;
    st_exp = fourth_converter_control[0] ? pmu_ctrl_pkg::START_FAST_CYC : pmu_ctrl_pkg::START_CYC;
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) cnt_ff <= 13'h0;
    else cnt_ff <= nxt_cnt;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Two clean edges needed before past values mean anything
  sequence s_set;
    $past(rst_n, 2);
  endsequence
  a_ldo_eco_follow: assert property (
    s_set |-> ldo_eco_on == $past(ldo_eco)) else $error("ldo eco mismatch");
  a_ldo_code_apply: assert property (
    s_set ##0 res_on[0] |-> ldo_vout_code[0] == $past(ldo_vsel[0])) else $error("ldo code stale");
  a_ldo_dis_gate: assert property (
    s_set |-> ldo_discharge_on == ($past(ldo_discharge) & ~res_on[9:0]))
    else $error("ldo discharge while on");
  a_conv_dis_gate: assert property (
    s_set |-> conv_discharge_on == ($past(conv_discharge & ~res_on[13:10]) & ~res_on[13:10]))
    else $error("conv discharge while on");
  a_conv_pwm_force: assert property (
    s_set |-> conv_pwm_force == $past(converter_forced_fixed_freq)) else $error("pwm mismatch");
  a_conv_eco_block: assert property (
    s_set |-> conv_eco_on == $past(conv_eco & ~converter_forced_fixed_freq))
    else $error("conv eco mismatch");
  a_off_clears_all: assert property (
    !device_on ##1 !device_on |-> res_on == 20'h0) else $error("resource on in off");
  a_ok_blanked: assert property (
    conv_output_ok[0] |-> $past(res_on[10]) && !$past(conv_soft_start[0]))
    else $error("ok not blanked");
  a_start_delay: assert property (
    $rose(conv_soft_start[3]) |-> cnt_ff >= st_exp - 2 && cnt_ff <= st_exp + 2)
    else $error("start delay wrong");
endmodule
bind pmu_power_control pmu_power_control_props u_props (.*);

// ===== host_model.sv
// Host side writer of regulator and converter control bits
`timescale 1ns/1ns
module host_model (
  // Clock
  input wire logic ref_clk,
  // Control bits
  output logic [9:0] ldo_eco,
  output logic [9:0] ldo_discharge,
  output logic [3:0] converter_forced_fixed_freq,
  output logic [3:0] conv_eco,
  output logic [3:0] conv_discharge
);
  logic [31:0] s = 32'hC492;
  initial {ldo_eco, ldo_discharge, converter_forced_fixed_freq, conv_eco, conv_discharge} = 32'h0;
  always @(posedge ref_clk) begin
    #1;
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    ldo_eco <= s[9:0];
    ldo_discharge <= s[19:10];
    converter_forced_fixed_freq <= s[23:20];
    conv_eco <= s[27:24] & s[31:28];
    conv_discharge <= s[31:28];
  end
endmodule

// ===== test_pmu_power_control.sv
// Self-checking bench for the power control block
`timescale 1ns/1ns
module test_pmu_power_control;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] en_pin, conv_pg_low, conv_fault_mask, converter_forced_fixed_freq;
  logic [3:0] conv_eco, conv_discharge, conv_pwm_force, conv_eco_on, conv_discharge_on;
  logic [3:0] conv_soft_start, conv_output_ok, conv_fault_event;
  logic clock_request_one, clock_request_two, power_request, power_on_cond, power_off_cond;
  logic temp_warn_cmp, temp_shutdown_cmp, thermal_flag_clear;
  logic device_on, temp_warning, thermal_shutdown_flag;
  logic [9:0] ldo_pg_cmp, ldo_eco, ldo_discharge, ldo_eco_on, ldo_discharge_on;
  logic [19:0] res_reg_enable, res_on;
  logic [19:0][3:0] res_slot;
  logic [6:0][19:0] req_map;
  logic [1:0] slot_spacing_field, temp_warn_level, output_ok_flags_second;
  logic [7:0] thermal_config_register, fourth_converter_control, output_ok_flags;
  logic [9:0][5:0] ldo_vsel, ldo_vout_code;
  logic [3:0][5:0] conv_vsel, conv_vout_code;
  logic [6:0] req;
  logic [31:0] seed = 32'hC492;
  int errors = 0;
  int total_checks = 0;
  int n;
  assign {power_request, clock_request_two, clock_request_one, en_pin} = req;
  pmu_power_control #(.SLOT_CYC1(20), .SLOT_CYC2(30), .SLOT_CYC3(40)) dut (.*);
  host_model u_host (.*);
  always #10 ref_clk = ~ref_clk;
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic int gap(input int s);
    return s == 0 ? pmu_ctrl_pkg::SLOT_CYC0 : s * 10 + 10;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  task automatic wait_on(input int k, input int lim);
    n = 0;
    while (res_on[k] !== 1'b1 && n < lim) begin
      tick(1);
      n++;
    end
  endtask
  task automatic final_report();
    $display("Checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Run needs near 0.5 ms; 1.6 ms leaves margin
  initial begin
    #1600000;
    errors++;
    final_report();
  end
  initial begin
    {req, power_on_cond, power_off_cond, temp_warn_cmp, temp_shutdown_cmp} = 11'h0;
    {thermal_flag_clear, ldo_pg_cmp, conv_pg_low, conv_fault_mask, res_reg_enable} = '0;
    {res_slot, req_map, slot_spacing_field, thermal_config_register} = '0;
    {fourth_converter_control, ldo_vsel, conv_vsel} = '0;
    res_slot[0] = 4'h1;
    res_slot[3] = 4'h1;
    res_slot[10] = 4'h2;
    res_slot[13] = 4'h3;
    res_slot[1] = 4'hF;
    tick(10);
    rst_n = 1'b1;
    req_map[0] = 20'h10000;
    req = 7'h01;
    tick(5);
    chk("off refusal", 0, {device_on, res_on});
    req = 7'h00;
    $display("Test reset done");
    for (int s = 3; s >= 0; s--) begin
      slot_spacing_field = 2'(s);
      fourth_converter_control = 8'(xs());
      power_on_cond = 1'b1;
      wait_on(0, 40000);
      wait_on(10, 3000);
      chk("slot gap", gap(s), n);
      chk("slot order", 0, res_on[1]);
      wait_on(1, 30000);
      chk("slot 15", 1, res_on[1]);
      power_on_cond = 1'b0;
      if (s > 0) begin
        power_off_cond = 1'b1;
        n = 0;
        while (device_on !== 1'b0 && n < 3000) begin
          tick(1);
          n++;
        end
        tick(2);
        chk("down", 0, res_on);
        power_off_cond = 1'b0;
      end
    end
    $display("Test sequencing done");
    for (int i = 0; i < 8; i++) begin
      ldo_vsel[0] = 6'(xs());
      ldo_vsel[3] = 6'(xs()) & 6'h1F;
      ldo_pg_cmp = 10'(xs());
      tick(4);
      chk("ldo1 code", ldo_vsel[0], ldo_vout_code[0]);
      chk("ldo4 code", ldo_vsel[3] | 6'h20, ldo_vout_code[3]);
      chk("ok flags", ldo_pg_cmp, {output_ok_flags_second, output_ok_flags});
    end
    $display("Test ldo done");
    for (int i = 0; i < 7; i++) begin
      req_map = '0;
      req_map[i] = 20'h10000;
      req_map[(i + 1) % 7] = 20'h10000;
      req = 7'(1 << i);
      tick(4);
      chk("pin on", 1, res_on[16]);
      req = req | 7'(1 << ((i + 1) % 7));
      tick(2);
      req = 7'(1 << ((i + 1) % 7));
      tick(4);
      chk("pin dominant", 1, res_on[16]);
      req = 7'h00;
      tick(4);
      chk("pin off", 0, res_on[16]);
    end
    res_reg_enable[17] = 1'b1;
    tick(2);
    chk("reg enable", 1, res_on[17]);
    $display("Test pins done");
    conv_vsel[0] = 6'(xs());
    tick(100);
    chk("conv code", conv_vsel[0], conv_vout_code[0]);
    chk("conv ok", 1, conv_output_ok[0]);
    chk("conv off ok", 0, conv_output_ok[1]);
    conv_pg_low = 4'h1;
    tick(4);
    chk("conv fault", 1, conv_fault_event[0]);
    chk("conv ok low", 0, conv_output_ok[0]);
    conv_fault_mask = 4'h1;
    tick(2);
    chk("fault masked", 0, conv_fault_event[0]);
    $display("Test converter done");
    thermal_config_register = 8'h05;
    temp_warn_cmp = 1'b1;
    tick(4);
    chk("warning", 1, temp_warning);
    chk("warn level", 2, temp_warn_level);
    thermal_config_register = 8'h04;
    tick(4);
    chk("warn off", 0, temp_warning);
    temp_shutdown_cmp = 1'b1;
    tick(5);
    chk("shutdown", 0, {device_on, res_on});
    chk("shut flag", 1, thermal_shutdown_flag);
    temp_shutdown_cmp = 1'b0;
    thermal_flag_clear = 1'b1;
    tick(4);
    chk("flag clear", 0, thermal_shutdown_flag);
    $display("Test thermal done");
    final_report();
  end
endmodule
